// ---- core/program_counter_unit.sv ----
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pc_unit_map.svh"
module program_counter_unit #(
    parameter int ADDR_W = 8,
    parameter int PMEM_BYTES = 32768
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pc_unit_pkg::core_req_t core_req,
    output logic [20:0] pmem_addr,
    input wire logic [15:0] pmem_rdata,
    output logic [15:0] instr_word,
    output logic [20:0] tos_value,
    output logic [4:0] return_stack_pointer
);

    localparam logic [21:0] PMEM_LIMIT = 22'(PMEM_BYTES);

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 32");
    end
    if (PMEM_BYTES < 2 || PMEM_BYTES > 2097152 || (PMEM_BYTES % 2) != 0) begin : g_bad_pmem
        $error("PMEM_BYTES must be even and within the 2 Mbyte space");
    end

    logic [20:0] pc_ff;
    logic [20:0] nxt_pc;
    logic [7:0] pc_high_latch_ff;
    logic [4:0] pc_upper_latch_ff;
    logic [20:0] tos_ff;
    logic [4:0] sp_ff;
    logic [15:0] instr_ff;
    pc_unit_pkg::pc_src_t pc_src;

    logic aw_full_ff;
    logic awready_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic w_full_ff;
    logic wready_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic wr_do;
    logic wr_low;
    logic wr_high;
    logic wr_upper;
    logic wr_mapped;
    logic rd_do;
    logic rd_low;
    logic rd_mapped;
    logic irq_take;
    logic [20:0] vector;
    logic [31:0] rd_word;

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    // fetch port is its own bus, so a fetch and a register access share a cycle
    assign pmem_addr = pc_ff;
    assign instr_word = instr_ff;
    assign tos_value = tos_ff;
    assign return_stack_pointer = sp_ff;

    // write decode; a write fires once both address and data are held and no write response is pending
    assign wr_do = aw_full_ff && w_full_ff && !bvalid_ff;
    assign wr_low = wr_do && aw_addr_ff == ADDR_W'(`PCU_OFF_LOW) && w_strb_ff[0];
    assign wr_high = wr_do && aw_addr_ff == ADDR_W'(`PCU_OFF_HIGH_LATCH) && w_strb_ff[0];
    assign wr_upper = wr_do && aw_addr_ff == ADDR_W'(`PCU_OFF_UPPER_LATCH) && w_strb_ff[0];
    assign wr_mapped = aw_addr_ff == ADDR_W'(`PCU_OFF_LOW) || aw_addr_ff == ADDR_W'(`PCU_OFF_HIGH_LATCH) ||
                       aw_addr_ff == ADDR_W'(`PCU_OFF_UPPER_LATCH) || aw_addr_ff == ADDR_W'(`PCU_OFF_PC_FULL) ||
                       aw_addr_ff == ADDR_W'(`PCU_OFF_TOS) || aw_addr_ff == ADDR_W'(`PCU_OFF_SP);

    assign rd_do = arvalid && arready_ff;
    assign rd_low = rd_do && araddr == ADDR_W'(`PCU_OFF_LOW);

    // the high and upper bytes never appear on their own; the full pc, tos and sp views are read-only
    always_comb begin
        rd_word = 32'h00000000;
        rd_mapped = 1'b1;
        case (araddr)
            ADDR_W'(`PCU_OFF_LOW): rd_word = {24'h000000, pc_ff[7:0]};
            ADDR_W'(`PCU_OFF_HIGH_LATCH): rd_word = {24'h000000, pc_high_latch_ff};
            ADDR_W'(`PCU_OFF_UPPER_LATCH): rd_word = {27'h0000000, pc_upper_latch_ff};
            ADDR_W'(`PCU_OFF_PC_FULL): rd_word = {11'h000, pc_ff};
            ADDR_W'(`PCU_OFF_TOS): rd_word = {11'h000, tos_ff};
            ADDR_W'(`PCU_OFF_SP): rd_word = {27'h0000000, sp_ff};
            default: rd_mapped = 1'b0;
        endcase
    end

    assign irq_take = core_req.irq_wake &&
                      (core_req.high_priority_global_irq_enable || core_req.low_priority_global_irq_enable);
    assign vector = core_req.irq_high_prio ? `PCU_HIGH_VECTOR : `PCU_LOW_VECTOR;

    // wake-up outranks software, software outranks the instruction stream
    always_comb begin
        if (irq_take) begin
            pc_src = pc_unit_pkg::src_vector;
        end else if (core_req.irq_wake) begin
            pc_src = pc_unit_pkg::src_wake_resume;
        end else if (wr_low) begin
            pc_src = pc_unit_pkg::src_sw_load;
        end else if (core_req.branch) begin
            pc_src = pc_unit_pkg::src_branch;
        end else if (core_req.step) begin
            pc_src = pc_unit_pkg::src_step;
        end else begin
            pc_src = pc_unit_pkg::src_hold;
        end
    end

    always_comb begin
        case (pc_src)
            pc_unit_pkg::src_vector: nxt_pc = vector;
            pc_unit_pkg::src_wake_resume: nxt_pc = pc_ff + `PCU_PC_STEP;
            pc_unit_pkg::src_sw_load: nxt_pc = {pc_upper_latch_ff, pc_high_latch_ff, w_data_ff[7:0]};
            pc_unit_pkg::src_branch: nxt_pc = core_req.target;
            pc_unit_pkg::src_step: nxt_pc = pc_ff + `PCU_PC_STEP;
            default: nxt_pc = pc_ff;
        endcase
    end

    // the wrap at the top of the 2 Mbyte space is silent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_ff <= `PCU_RESET_VECTOR;
        end else begin
            pc_ff <= {nxt_pc[20:1], 1'b0};
        end
    end

    // a register write in the same cycle as a low byte read wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_high_latch_ff <= 8'h00;
            pc_upper_latch_ff <= 5'h00;
        end else begin
            if (rd_low) begin
                pc_high_latch_ff <= pc_ff[15:8];
                pc_upper_latch_ff <= pc_ff[20:16];
            end
            if (wr_high) begin
                pc_high_latch_ff <= w_data_ff[7:0];
            end
            if (wr_upper) begin
                pc_upper_latch_ff <= w_data_ff[4:0];
            end
        end
    end

    // pointer saturates at PCU_SP_MAX; nothing in this unit ever pops it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tos_ff <= 21'h000000;
            sp_ff <= 5'h00;
        end else if (irq_take) begin
            tos_ff <= pc_ff;
            if (sp_ff != `PCU_SP_MAX) begin
                sp_ff <= sp_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_ff <= 16'h0000;
        end else if ({1'b0, pc_ff} >= PMEM_LIMIT) begin
            instr_ff <= 16'h0000;
        end else begin
            instr_ff <= pmem_rdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            awready_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (awvalid && awready_ff) begin
            aw_full_ff <= 1'b1;
            awready_ff <= 1'b0;
            aw_addr_ff <= awaddr;
        end else if (wr_do) begin
            aw_full_ff <= 1'b0;
            awready_ff <= 1'b1;
        end else begin
            awready_ff <= !aw_full_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_ff <= 1'b0;
            wready_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else if (wvalid && wready_ff) begin
            w_full_ff <= 1'b1;
            wready_ff <= 1'b0;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
        end else if (wr_do) begin
            w_full_ff <= 1'b0;
            wready_ff <= 1'b1;
        end else begin
            wready_ff <= !w_full_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `PCU_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? `PCU_RESP_OKAY : `PCU_RESP_SLVERR;
        end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `PCU_RESP_OKAY;
        end else if (rd_do) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_mapped ? `PCU_RESP_OKAY : `PCU_RESP_SLVERR;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end else begin
            arready_ff <= !rvalid_ff;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic rst_seen_ff;
    always_ff @(posedge aclk) begin
        rst_seen_ff <= !aresetn;
    end

    a_reset_vector: assert property (rst_seen_ff |-> pc_ff == `PCU_RESET_VECTOR)
        else $error("pc not at reset vector after reset");
    a_pc_aligned: assert property (##1 pc_ff[0] == 1'b0 && pmem_addr[0] == 1'b0)
        else $error("pc bit 0 not zero");
    a_seq_step: assert property (pc_src == pc_unit_pkg::src_step |=> pc_ff == $past(pc_ff) + `PCU_PC_STEP)
        else $error("sequential step not by two");
    a_irq_vector: assert property (irq_take |=> pc_ff == ($past(core_req.irq_high_prio) ? 21'h000008 : 21'h000018))
        else $error("wake-up did not load vector");
    a_irq_push: assert property (irq_take && sp_ff != 5'h1F |=> tos_ff == $past(pc_ff) && sp_ff == $past(sp_ff) + 5'h01)
        else $error("wake-up push wrong");
    a_low_write_load: assert property (pc_src == pc_unit_pkg::src_sw_load |=>
        pc_ff[20:8] == {$past(pc_upper_latch_ff), $past(pc_high_latch_ff)})
        else $error("low byte write did not copy latches");
    a_low_read_copy: assert property (rd_low && !wr_high && !wr_upper |=>
        pc_high_latch_ff == $past(pc_ff[15:8]) && pc_upper_latch_ff == $past(pc_ff[20:16]))
        else $error("low byte read did not load latches");
    // a same-cycle latch write or low byte read legitimately moves the latch
    a_branch_direct: assert property (pc_src == pc_unit_pkg::src_branch && !wr_high && !rd_low |=>
        pc_ff == {$past(core_req.target[20:1]), 1'b0} && $stable(pc_high_latch_ff))
        else $error("branch target not loaded directly");
    a_nop_beyond: assert property ({1'b0, pc_ff} >= PMEM_LIMIT |=> instr_word == 16'h0000)
        else $error("fetch beyond memory not zero");
    a_low_read_data: assert property (rd_low |=> rvalid && rdata == {24'h000000, $past(pc_ff[7:0])})
        else $error("low byte read data wrong");

    c_irq_taken: cover property (irq_take ##1 pc_ff == 21'h000008);
    c_sw_load: cover property (wr_high ##[1:20] wr_low);
    c_read_low: cover property (rd_low ##1 rvalid && rready);
    c_beyond: cover property ({1'b0, pc_ff} >= PMEM_LIMIT);

endmodule
`default_nettype wire

// ---- core/pc_unit_map.svh ----
`ifndef PC_UNIT_MAP_SVH
`define PC_UNIT_MAP_SVH

`define PCU_PC_W 21
`define PCU_RESET_VECTOR 21'h000000
`define PCU_HIGH_VECTOR 21'h000008
`define PCU_LOW_VECTOR 21'h000018
`define PCU_PC_STEP 21'h000002
`define PCU_SP_MAX 5'h1F

`define PCU_OFF_LOW 8'h00
`define PCU_OFF_HIGH_LATCH 8'h04
`define PCU_OFF_UPPER_LATCH 8'h08
`define PCU_OFF_PC_FULL 8'h0C
`define PCU_OFF_TOS 8'h10
`define PCU_OFF_SP 8'h14

`define PCU_RESP_OKAY 2'h0
`define PCU_RESP_SLVERR 2'h2

`endif

// ---- core/pc_unit_pkg.sv ----
`default_nettype none
package pc_unit_pkg;

    typedef struct packed {
        logic step;
        logic branch;
        logic [20:0] target;
        logic irq_wake;
        logic irq_high_prio;
        logic high_priority_global_irq_enable;
        logic low_priority_global_irq_enable;
    } core_req_t;

    typedef enum logic [2:0] {
        src_hold = 3'b000,
        src_step = 3'b001,
        src_branch = 3'b010,
        src_sw_load = 3'b011,
        src_vector = 3'b100,
        src_wake_resume = 3'b101
    } pc_src_t;

endpackage
`default_nettype wire

// ---- tb/prog_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// instruction-side memory on its own bus; a word reads as zero only where addr[15:0] is 16'h5A3C
module prog_mem_model (
    input wire logic [20:0] addr,
    output logic [15:0] data
);
    assign data = addr[15:0] ^ 16'h5A3C;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pc_unit_map.svh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    pc_unit_pkg::core_req_t core_req = '0;
    logic [20:0] pmem_addr, tos_value;
    logic [15:0] pmem_rdata, instr_word;
    logic [4:0] return_stack_pointer;
    int fails = 0, num_checks = 0, cycles = 0;

    always #5 aclk = ~aclk;

    // small memory so that an address past it is easy to reach
    program_counter_unit #(.ADDR_W(8), .PMEM_BYTES(64)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .core_req(core_req), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
        .instr_word(instr_word), .tos_value(tos_value), .return_stack_pointer(return_stack_pointer)
    );
    prog_mem_model mem (.addr(pmem_addr), .data(pmem_rdata));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // one request held for exactly one sampling edge
    task automatic core_op(input pc_unit_pkg::core_req_t r);
        @(posedge aclk);
        core_req <= r;
        @(posedge aclk);
        core_req <= '0;
        @(negedge aclk);
    endtask

    task automatic do_reset(input int n);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("pc", 32'h0, 32'(pmem_addr));
        chk("sp", 32'h0, 32'(return_stack_pointer));
        $display("reset test done");
    endtask

    task automatic t_step();
        @(posedge aclk);
        core_req.step <= 1'b1;
        repeat (3) @(posedge aclk);
        core_req.step <= 1'b0;
        @(negedge aclk);
        chk("pc", 32'h6, 32'(pmem_addr));
        chk("instr", 32'(16'h0004 ^ 16'h5A3C), 32'(instr_word));
        $display("step test done");
    endtask

    task automatic t_sw_load();
        axi_wr(`PCU_OFF_HIGH_LATCH, 32'h12);
        chk("bresp", 32'(`PCU_RESP_OKAY), 32'(resp));
        axi_wr(`PCU_OFF_UPPER_LATCH, 32'h01);
        chk("pc", 32'h6, 32'(pmem_addr));
        // odd value: bit 0 must not reach the pc
        axi_wr(`PCU_OFF_LOW, 32'h35);
        @(negedge aclk);
        chk("pc", 32'h011234, 32'(pmem_addr));
        @(negedge aclk);
        chk("instr", 32'h0, 32'(instr_word));
        $display("load test done");
    endtask

    task automatic t_branch();
        pc_unit_pkg::core_req_t q;
        q = '0;
        q.branch = 1'b1;
        q.target = 21'h0A5679;
        core_op(q);
        chk("pc", 32'h0A5678, 32'(pmem_addr));
        axi_rd(`PCU_OFF_HIGH_LATCH);
        chk("high latch", 32'h12, rd & 32'hFF);
        axi_rd(`PCU_OFF_LOW);
        chk("low byte", 32'h78, rd & 32'hFF);
        axi_rd(`PCU_OFF_HIGH_LATCH);
        chk("high latch", 32'h56, rd & 32'hFF);
        axi_rd(`PCU_OFF_UPPER_LATCH);
        chk("upper latch", 32'h0A, rd & 32'h1F);
        axi_rd(`PCU_OFF_PC_FULL);
        chk("full pc", 32'h0A5678, rd & 32'h1FFFFF);
        $display("branch test done");
    endtask

    task automatic t_irq();
        pc_unit_pkg::core_req_t q;
        logic [20:0] pcs [4];
        pcs = '{21'h0A5678, 21'h000008, 21'h000018, 21'h00001A};
        // high vector, low vector, then a wake with both enables clear
        for (int i = 0; i < 3; i++) begin
            q = '0;
            q.irq_wake = 1'b1;
            q.irq_high_prio = (i == 0);
            q.high_priority_global_irq_enable = (i == 0);
            q.low_priority_global_irq_enable = (i == 1);
            core_op(q);
            chk("pc", 32'(pcs[i + 1]), 32'(pmem_addr));
            chk("tos", 32'(pcs[(i < 2) ? i : 1]), 32'(tos_value));
            chk("sp", (i < 2) ? i + 1 : 2, 32'(return_stack_pointer));
        end
        $display("wake test done");
    endtask

    task automatic t_bus();
        axi_wr(8'h40, 32'hFF);
        chk("bresp", 32'(`PCU_RESP_SLVERR), 32'(resp));
        axi_rd(8'h40);
        chk("rresp", 32'(`PCU_RESP_SLVERR), 32'(resp));
        chk("rdata", 32'h0, rd);
        axi_wr(`PCU_OFF_PC_FULL, 32'h0);
        chk("pc", 32'h1A, 32'(pmem_addr));
        // a write without the low byte lane must leave the latch alone
        wstrb <= 4'h0;
        axi_wr(`PCU_OFF_HIGH_LATCH, 32'h77);
        wstrb <= 4'hF;
        axi_rd(`PCU_OFF_HIGH_LATCH);
        chk("high latch", 32'h56, rd & 32'hFF);
        $display("bus test done");
    endtask

    initial begin
        do_reset(5);
        t_step();
        t_sw_load();
        t_branch();
        t_irq();
        t_bus();
        do_reset(2);
        end_sim();
    end
endmodule
`default_nettype wire
